//--- common/pwm_pair_pkg.sv
// Constants shared by the two-channel 10-bit pulse-width modulator.
// Assumes a single 100 MHz clock and an AXI4-Lite register bus.
`default_nettype none

package pwm_pair_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL0  = 5'h00;  // First channel control.
  localparam logic [4:0] OFS_DUTYH0 = 5'h04;  // First channel duty high bits.
  localparam logic [4:0] OFS_DUTYL0 = 5'h08;  // First channel duty low bits.
  localparam logic [4:0] OFS_CTRL1  = 5'h0c;  // Second channel control.
  localparam logic [4:0] OFS_DUTYH1 = 5'h10;  // Second channel duty high bits.
  localparam logic [4:0] OFS_DUTYL1 = 5'h14;  // Second channel duty low bits.
  localparam logic [4:0] OFS_TSEL   = 5'h18;  // Shared timer select.

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE = 7;  // Channel enable.
  localparam int BIT_OUTLVL = 5;  // Output level readback.
  localparam int BIT_POL    = 4;  // Output polarity select.
  localparam int BIT_DUTYLO = 6;  // Lowest position of the two duty LSBs.
  localparam int BIT_TSEL1  = 2;  // Second channel field low bit.
  localparam int BIT_TSEL0  = 0;  // First channel field low bit.

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic [1:0] TSEL_RESET = 2'h1;  // Both fields pick the first timer.
  localparam logic [9:0] DUTY_RESET = 10'h000;

  // Timer select codes.
  localparam logic [1:0] TSEL_RSVD = 2'h0;
  localparam logic [1:0] TSEL_T1   = 2'h1;
  localparam logic [1:0] TSEL_T2   = 2'h2;
  localparam logic [1:0] TSEL_T3   = 2'h3;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

//--- logic/pwm_channel.sv
// One modulation channel: buffered duty, compare and polarity.
// Assumes a selected period-match pulse and a 10-bit time base on mclk.
`default_nettype none

module pwm_channel
  import pwm_pair_pkg::*;
(
  input  wire logic       mclk,          // System clock.
  input  wire logic       rst,           // Synchronous reset, active high.
  input  wire logic       channelEnable, // Channel runs while high.
  input  wire logic       polarity,      // High selects active-low output.
  input  wire logic [9:0] dutyValue,     // Software duty value.
  input  wire logic       periodMatch,   // Restart instant of selected timer.
  input  wire logic [9:0] timeBase,      // Extended 10-bit time base.
  output logic            outputLevel    // Modulated pin level.
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  logic [9:0] latchedDuty_ff;  // Duty in force for this period.
  logic       active_ff;       // Pulse phase before polarity.
  logic       outLevel_ff;     // Registered pin level.

  // Next-state terms.
  logic [9:0] nxt_latchedDuty;
  logic       nxt_active;
  logic       dutyReached;

  assign dutyReached = (timeBase == latchedDuty_ff);

  // Duty latches only at the restart instant so a write never glitches.
  assign nxt_latchedDuty = periodMatch ? dutyValue : latchedDuty_ff;

  // Restart sets the pulse unless the new duty is zero; reaching the duty clears it.
  assign nxt_active = !channelEnable ? 1'b0 :
                      periodMatch    ? (dutyValue != DUTY_RESET) :
                      dutyReached    ? 1'b0 : active_ff;

  // Register the duty and pulse phase.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      latchedDuty_ff <= DUTY_RESET;
      active_ff      <= 1'b0;
      outLevel_ff    <= 1'b0;
    end
    else
    begin
      latchedDuty_ff <= nxt_latchedDuty;
      active_ff      <= nxt_active;
      // Disabled channels sit at the idle level set by polarity.
      outLevel_ff    <= nxt_active ^ polarity;
    end
  end

  assign outputLevel = outLevel_ff;

endmodule

`default_nettype wire

//--- logic/pwm_pair.sv
// Two 10-bit pulse-width modulation channels behind an AXI4-Lite slave.
// Assumes three external 8-bit period timers supply counts, prescaler
// phase bits and period-match pulses on the mclk domain.
//
// Notes on behaviour
// - Channel modulates only while enable bit 7 set.
// - Control bit 5 reads present output level.
// - Polarity bit 4 one makes output active-low.
// - Duty high register holds duty bits nine-two.
// - Duty low bits 7:6 hold LSBs; rest zero.
// - Second channel timer field bits 3:2, reset 01.
// - First channel timer field bits 1:0, reset 01.
// - Unimplemented bits ignore writes, read zero.
// - Period match restarts, latches duty, sets output unless new duty zero.
// - Duty writes buffered, applied at next match.
// - Disabled output sits at polarity idle level.
// - Time base is timer count plus two bits.
`default_nettype none

module pwm_pair
  import pwm_pair_pkg::*;
(
  input  wire logic        mclk,           // System clock, 100 MHz.
  input  wire logic        rst,            // Synchronous reset, active high.
  // AXI4-Lite write address channel.
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [4:0]  s_axi_awaddr,
  // AXI4-Lite write data channel.
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response channel.
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address channel.
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [4:0]  s_axi_araddr,
  // AXI4-Lite read data channel.
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Period timers, index 0 is the first timer.
  input  wire logic [23:0] timerCount,     // Three 8-bit counts.
  input  wire logic [5:0]  timerPhase,     // Three 2-bit clock or prescaler phases.
  input  wire logic [2:0]  timerMatch,     // Increment after count equals period.
  // Modulated outputs toward the load.
  output logic             firstChannelOut,
  output logic             secondChannelOut
);

  // ----------------------------------------------------------------
  // Register storage.
  // ----------------------------------------------------------------
  logic [1:0] enable_ff;      // Channel enables.
  logic [1:0] polarity_ff;    // Channel polarity selects.
  logic [9:0] duty_ff [2];    // Software duty values.
  logic [1:0] tsel_ff [2];    // Timer select fields.

  // Write path holding registers.
  logic        awHeld_ff;     // Write address captured.
  logic        wHeld_ff;      // Write data captured.
  logic [4:0]  awAddr_ff;
  logic [7:0]  wData_ff;      // Low data byte; the upper lanes carry no register bits.
  logic        wStrb0_ff;     // Low byte lane strobe.
  logic        bValid_ff;
  logic [1:0]  bResp_ff;
  // Read path registers.
  logic        rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0]  rResp_ff;

  // Channel outputs.
  logic [1:0] chanOut;

  // ----------------------------------------------------------------
  // Decoding helpers.
  // ----------------------------------------------------------------
  // True when the address names an implemented register.
  function automatic logic isMapped(input logic [4:0] addr);
    isMapped = (addr == OFS_CTRL0) || (addr == OFS_DUTYH0) || (addr == OFS_DUTYL0) ||
               (addr == OFS_CTRL1) || (addr == OFS_DUTYH1) || (addr == OFS_DUTYL1) ||
               (addr == OFS_TSEL);
  endfunction

  // Timer index for a select code; the reserved code falls back to the first
  // timer so that the selection never reaches past the last timer.
  function automatic logic [1:0] timerIndex(input logic [1:0] code);
    timerIndex = (code == TSEL_RSVD) ? 2'h0 : code - 2'h1;
  endfunction

  // ----------------------------------------------------------------
  // Write channel.
  // ----------------------------------------------------------------
  // Address and data may arrive in either order; each is held until both are in.
  assign s_axi_awready = !awHeld_ff && !bValid_ff;
  assign s_axi_wready  = !wHeld_ff && !bValid_ff;

  wire logic doWrite = awHeld_ff && wHeld_ff && !bValid_ff;  // Commit cycle.
  wire logic wrOk    = doWrite && wStrb0_ff && isMapped(awAddr_ff);
  wire logic [7:0] wByte = wData_ff;

  // Capture address, data and produce the response.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      awAddr_ff <= 5'h00;
      wData_ff  <= 8'h00;
      wStrb0_ff <= 1'b0;
      bValid_ff <= 1'b0;
      bResp_ff  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_ff  <= 1'b1;
        wData_ff  <= s_axi_wdata[7:0];
        wStrb0_ff <= s_axi_wstrb[0];
      end
      if (doWrite)
      begin
        // Commit finished: free both holders and answer.
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
        bValid_ff <= 1'b1;
        bResp_ff  <= isMapped(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bValid_ff && s_axi_bready)
      begin
        bValid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp  = bResp_ff;

  // ----------------------------------------------------------------
  // Register file, one copy per channel.
  // ----------------------------------------------------------------
  // Only implemented bits are stored, so unused bits cannot be written.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : gChan
      localparam logic [4:0] CTRL  = (ch == 0) ? OFS_CTRL0  : OFS_CTRL1;
      localparam logic [4:0] DUTYH = (ch == 0) ? OFS_DUTYH0 : OFS_DUTYH1;
      localparam logic [4:0] DUTYL = (ch == 0) ? OFS_DUTYL0 : OFS_DUTYL1;
      localparam int         TBIT  = (ch == 0) ? BIT_TSEL0  : BIT_TSEL1;

      // Update control, duty and timer select fields of this channel.
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          enable_ff[ch]   <= 1'b0;
          polarity_ff[ch] <= 1'b0;
          duty_ff[ch]     <= DUTY_RESET;
          tsel_ff[ch]     <= TSEL_RESET;
        end
        else if (wrOk)
        begin
          if (awAddr_ff == CTRL)
          begin
            enable_ff[ch]   <= wByte[BIT_ENABLE];
            polarity_ff[ch] <= wByte[BIT_POL];
          end
          if (awAddr_ff == DUTYH)
          begin
            duty_ff[ch][9:2] <= wByte;
          end
          if (awAddr_ff == DUTYL)
          begin
            duty_ff[ch][1:0] <= wByte[BIT_DUTYLO +: 2];
          end
          if (awAddr_ff == OFS_TSEL)
          begin
            tsel_ff[ch] <= wByte[TBIT +: 2];
          end
        end
      end

      // Time base and restart for the selected timer.
      wire logic [1:0] tIdx  = timerIndex(tsel_ff[ch]);
      wire logic       tRsvd = (tsel_ff[ch] == TSEL_RSVD);
      // Count forms the upper eight bits, the phase bits the lower two.
      wire logic [9:0] tBase = {timerCount[tIdx * 8 +: 8], timerPhase[tIdx * 2 +: 2]};
      // A reserved code gives no restart; a pulse in progress still ends at its duty.
      wire logic       tMatch = !tRsvd && timerMatch[tIdx];

      pwm_channel uChannel
      (
        .mclk          (mclk),
        .rst           (rst),
        .channelEnable (enable_ff[ch]),
        .polarity      (polarity_ff[ch]),
        .dutyValue     (duty_ff[ch]),
        .periodMatch   (tMatch),
        .timeBase      (tBase),
        .outputLevel   (chanOut[ch])
      );
    end
  endgenerate

  assign firstChannelOut  = chanOut[0];
  assign secondChannelOut = chanOut[1];

  // ----------------------------------------------------------------
  // Read channel.
  // ----------------------------------------------------------------
  assign s_axi_arready = !rValid_ff;

  // Read value of each register; reserved bits are zero.
  wire logic [7:0] ctrlRd0 = {enable_ff[0], 1'b0, chanOut[0], polarity_ff[0], 4'h0};
  wire logic [7:0] ctrlRd1 = {enable_ff[1], 1'b0, chanOut[1], polarity_ff[1], 4'h0};
  wire logic [7:0] dutyL0  = {duty_ff[0][1:0], 6'h00};
  wire logic [7:0] dutyL1  = {duty_ff[1][1:0], 6'h00};
  wire logic [7:0] tselRd  = {4'h0, tsel_ff[1], tsel_ff[0]};

  // Select the byte that the read address names.
  logic [7:0] rdByte;
  always_comb
  begin
    unique case (s_axi_araddr)
      OFS_CTRL0:  rdByte = ctrlRd0;
      OFS_DUTYH0: rdByte = duty_ff[0][9:2];
      OFS_DUTYL0: rdByte = dutyL0;
      OFS_CTRL1:  rdByte = ctrlRd1;
      OFS_DUTYH1: rdByte = duty_ff[1][9:2];
      OFS_DUTYL1: rdByte = dutyL1;
      OFS_TSEL:   rdByte = tselRd;
      default:    rdByte = 8'h00;  // Unmapped addresses read zero.
    endcase
  end

  // Capture read data on the edge that takes the address.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rValid_ff <= 1'b0;
      rData_ff  <= 32'h00000000;
      rResp_ff  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rValid_ff <= 1'b1;
      rData_ff  <= {24'h000000, rdByte};
      rResp_ff  <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rValid_ff && s_axi_rready)
    begin
      rValid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata  = rData_ff;
  assign s_axi_rresp  = rResp_ff;

endmodule

`default_nettype wire

//--- verif/pwm_pair_props.sv
// Checker for the bus ports and the first channel pin of the modulator pair.
// Assumes it is bound onto pwm_pair and sees only its ports.
`default_nettype none

module pwm_pair_props
  import pwm_pair_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [4:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        firstChannelOut
);
  // ----
  // Bus and readback checks.
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // A read address that is taken gets its answer on the next cycle.
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Read data stays put until it is taken.
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // A write response stays put until it is taken.
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  // Both halves taken together answer two cycles later.
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  // No new read is taken while an answer waits.
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overrun");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  tsel_rsvd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_TSEL
    |=> s_axi_rdata[7:4] == 4'h0) else $error("select spare bits set");
  dutyl_zero_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_DUTYL0
    |=> s_axi_rdata[5:0] == 6'h0) else $error("duty low spare bits set");
  level_rb_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_CTRL0
    |=> s_axi_rdata[5] == $past(firstChannelOut)) else $error("level readback wrong");
  // Reads above the select offset answer an error with zero data.
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFS_TSEL
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  // Main traffic seen.
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(firstChannelOut));
endmodule

`default_nettype wire

//--- verif/pwm_load_model.sv
// Load on a modulated pin: measures high time and period.
// Assumes the pin is a plain level on mclk.
`default_nettype none

module pwm_load_model
(
  input  wire logic        mclk,
  input  wire logic        pin,
  output logic [15:0]      width_ff,
  output logic [15:0]      period_ff
);
  logic [15:0] cnt_ff = 16'h0;  // Cycles since the last rising edge.
  logic        pinDly_ff = 1'b0; // Pin one cycle ago.
  // A rising edge closes a period, a falling edge closes a pulse.
  always_ff @(posedge mclk)
  begin
    pinDly_ff <= pin;
    cnt_ff <= (pin && !pinDly_ff) ? 16'h1 : cnt_ff + 16'h1;
    if (pin && !pinDly_ff)
      period_ff <= cnt_ff;
    if (!pin && pinDly_ff)
      width_ff <= cnt_ff;
  end
endmodule

`default_nettype wire

//--- verif/pwm_pair_bench.sv
// Self-checking bench for the modulator pair.
// Assumes the pair, its checker and the load model are compiled first.
`default_nettype none
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin errCount++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end

module pwm_pair_bench
  import pwm_pair_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  int          errCount = 0;
  int          numChecks = 0;
  int          cyc = 0;
  int          rdyLag = 0;                  // Cycles before bready or rready rises.
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        firstChannelOut, secondChannelOut;
  logic [1:0]  ph = 2'h0;                   // Shared clock phase, 1:4 prescale.
  logic [7:0]  tCnt [3] = '{default: 8'h0}; // Timer counts, period k+3.
  logic [2:0]  timerMatch = 3'h0;
  logic [15:0] w1w, w1p, w2w, w2p;
  wire  [23:0] timerCount = {tCnt[2], tCnt[1], tCnt[0]};
  wire  [5:0]  timerPhase = {3{ph}};

  pwm_pair DUT (.mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .timerCount, .timerPhase, .timerMatch, .firstChannelOut,
    .secondChannelOut);
  pwm_load_model ld1 (.mclk, .pin(firstChannelOut), .width_ff(w1w), .period_ff(w1p));
  pwm_load_model ld2 (.mclk, .pin(secondChannelOut), .width_ff(w2w), .period_ff(w2p));

  initial
  begin
    forever #5 mclk = ~mclk;
  end
  // Three timers; the match pulse lands with the count back at zero.
  always @(posedge mclk)
  begin
    cyc++;
    ph <= rst ? 2'h0 : ph + 2'h1;
    for (int k = 0; k < 3; k++)
    begin
      timerMatch[k] <= !rst && ph == 2'h3 && tCnt[k] == 8'(k + 3);
      tCnt[k] <= (rst || (ph == 2'h3 && tCnt[k] == 8'(k + 3))) ? 8'h0 : tCnt[k] + 8'(ph == 2'h3);
    end
    // A run that hangs counts as a mismatch and ends at the report.
    if (cyc == 6000)
    begin
      errCount++;
      report_and_stop();
    end
  end

  // Write one register; both halves offered at once, held until taken.
  task automatic wrChk(input logic [4:0] a, input logic [7:0] d, input logic [1:0] e);
    logic ga, gw, gb;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (rdyLag == 0);
    do
    begin
      @(negedge mclk);
      ga = s_axi_awvalid && s_axi_awready;
      gw = s_axi_wvalid && s_axi_wready;
      gb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge mclk);
      n++;
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
      if (!gb && n >= rdyLag) s_axi_bready <= 1'b1;
    end while (!gb);
    s_axi_bready <= 1'b0;
    `CHK("write resp", e, r)
  endtask
  // Read one register and compare its low byte and response.
  task automatic rdChk(input logic [4:0] a, input logic [7:0] e, input logic [1:0] er);
    logic ga, gr;
    logic [7:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (rdyLag == 0);
    do
    begin
      @(negedge mclk);
      ga = s_axi_arvalid && s_axi_arready;
      gr = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      @(posedge mclk);
      n++;
      if (ga) s_axi_arvalid <= 1'b0;
      if (!gr && n >= rdyLag) s_axi_rready <= 1'b1;
    end while (!gr);
    s_axi_rready <= 1'b0;
    `CHK("read data", e, d)
    `CHK("read resp", er, r)
  endtask
  // The first pin must sit at one level for a long stretch.
  task automatic hold(input logic e);
    int bad;
    bad = 0;
    repeat (30) @(posedge mclk);
    repeat (48) @(negedge mclk) bad += int'(firstChannelOut !== e);
    `CHK("steady pin", 0, bad)
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdChk(OFS_CTRL0, 8'h00, RESP_OKAY);
    rdChk(OFS_TSEL, 8'h05, RESP_OKAY);
    wrChk(OFS_CTRL0, 8'h6f, RESP_OKAY);
    rdChk(OFS_CTRL0, 8'h00, RESP_OKAY);
    wrChk(OFS_TSEL, 8'hf6, RESP_OKAY);
    rdChk(OFS_TSEL, 8'h06, RESP_OKAY);
    wrChk(OFS_DUTYH1, 8'hff, RESP_OKAY);
    rdChk(OFS_DUTYH1, 8'hff, RESP_OKAY);
    // A write with the low byte lane off leaves the register alone.
    s_axi_wstrb <= 4'h0;
    wrChk(OFS_DUTYH1, 8'h55, RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    rdChk(OFS_DUTYH1, 8'hff, RESP_OKAY);
    wrChk(OFS_DUTYL1, 8'hff, RESP_OKAY);
    rdChk(OFS_DUTYL1, 8'hc0, RESP_OKAY);
    wrChk(5'h1c, 8'h12, RESP_SLVERR);
    rdChk(5'h1c, 8'h00, RESP_SLVERR);
    wrChk(OFS_CTRL1, 8'h10, RESP_OKAY);
    rdChk(OFS_CTRL1, 8'h30, RESP_OKAY);
    // Duty 5 on the first channel, 9 active-low on the second.
    wrChk(OFS_DUTYH0, 8'h01, RESP_OKAY);
    rdyLag = 3;  // Late ready makes the answers wait.
    wrChk(OFS_DUTYL0, 8'h40, RESP_OKAY);
    rdChk(OFS_DUTYL0, 8'h40, RESP_OKAY);
    rdyLag = 0;
    wrChk(OFS_DUTYH1, 8'h02, RESP_OKAY);
    wrChk(OFS_DUTYL1, 8'h40, RESP_OKAY);
    wrChk(OFS_CTRL0, 8'h80, RESP_OKAY);
    wrChk(OFS_CTRL1, 8'h90, RESP_OKAY);
    for (int s = 1; s <= 3; s++)
    begin
      wrChk(OFS_TSEL, 8'(s * 5), RESP_OKAY);
      repeat (80) @(posedge mclk);
      `CHK("first period", 16'(4 * (s + 3)), w1p)
      `CHK("first width", 16'h5, w1w)
      `CHK("second period", 16'(4 * (s + 3)), w2p)
      `CHK("second width", 16'(4 * (s + 3) - 9), w2w)
    end
    // A duty change in mid-pulse waits for the next restart.
    do @(negedge mclk); while (!timerMatch[2]);
    wrChk(OFS_DUTYL0, 8'hc0, RESP_OKAY);
    repeat (12) @(posedge mclk);
    `CHK("old width", 16'h5, w1w)
    repeat (30) @(posedge mclk);
    `CHK("new width", 16'h7, w1w)
    wrChk(OFS_DUTYH0, 8'hff, RESP_OKAY);
    hold(1'b1);
    wrChk(OFS_DUTYH0, 8'h00, RESP_OKAY);
    wrChk(OFS_DUTYL0, 8'h00, RESP_OKAY);
    hold(1'b0);
    wrChk(OFS_DUTYH0, 8'h01, RESP_OKAY);
    wrChk(OFS_CTRL0, 8'h00, RESP_OKAY);
    hold(1'b0);
    wrChk(OFS_CTRL0, 8'h10, RESP_OKAY);
    hold(1'b1);
    rdChk(OFS_CTRL0, 8'h30, RESP_OKAY);
    report_and_stop();
  end
endmodule

bind pwm_pair pwm_pair_props chk (.mclk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .firstChannelOut);

`default_nettype wire
